// ---- core/csr_status_regs.sv ----
// Purpose: Charger loop and phase/adapter status registers with event latches
// Assumes: Serial interface engine presents single-cycle register reads
// Notes: Status is sampled every cycle from live conditions
`default_nettype none
module csr_status_regs #(
  parameter bit HAS_ADAPTER_DETECT = 1'b1,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire csr_pkg::csr_loops_s loops,
  input wire csr_pkg::csr_mode_s mode,
  input wire csr_pkg::csr_adapter_s adapter,
  input wire logic [1:0] charge_phase_in,
  input wire logic conv_continuous,
  input wire logic conv_start,
  input wire logic conv_finish,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [csr_pkg::NUM_EVENTS-1:0] event_clear,
  output logic [DATA_W-1:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  output logic [DATA_W-1:0] charger_loop_status_ff,
  output logic [DATA_W-1:0] charge_phase_adapter_status_ff,
  output logic [csr_pkg::NUM_EVENTS-1:0] watchdog_event_latch_ff
);
  import csr_pkg::*;

  // Elaboration check on data width
  if (DATA_W != 8) begin : g_bad_width
    $error("csr_status_regs supports only 8-bit registers");
  end

  // ----------------------------------------------------------------
  // Conversion-done tracking
  // ----------------------------------------------------------------
  logic conv_done_ff;
  logic nxt_conv_done;

  // Pending until finish; finish wins over a same-cycle start
  always_comb begin
    nxt_conv_done = conv_done_ff;
    if (conv_start) begin
      nxt_conv_done = 1'b0;
    end
    if (conv_finish) begin
      nxt_conv_done = 1'b1;
    end
    if (conv_continuous) begin
      nxt_conv_done = 1'b0;
    end
  end

  // Conversion-done flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_done_ff <= 1'b0;
    end else begin
      conv_done_ff <= nxt_conv_done;
    end
  end

  // ----------------------------------------------------------------
  // Loop status decode
  // ----------------------------------------------------------------
  logic thermal_bit;
  logic system_minimum_bit;
  logic current_loop_bit;
  logic voltage_loop_bit;
  logic charge_timer_expired_bit;
  logic host_watchdog_expired_bit;
  logic [DATA_W-1:0] nxt_loop_status;

  // Per-mode selection of loop indications
  always_comb begin
    thermal_bit = loops.thermal_active;
    system_minimum_bit = mode.forward_mode && loops.sys_min_active;
    current_loop_bit = 1'b0;
    if (mode.forward_mode) begin
      current_loop_bit = loops.in_cur_active || loops.limit_pin_active;
    end else if (mode.boost_mode) begin
      current_loop_bit = loops.boost_cur_active;
    end
    voltage_loop_bit = 1'b0;
    if (mode.forward_mode) begin
      voltage_loop_bit = loops.in_volt_active;
    end else if (mode.boost_mode || mode.backup_mode) begin
      voltage_loop_bit = loops.boost_volt_active;
    end
    charge_timer_expired_bit = loops.timer_expired;
    host_watchdog_expired_bit = loops.watchdog_expired;
  end

  // Pack the first status register; bit 7 stays zero
  always_comb begin
    nxt_loop_status = STATUS_RESET;
    nxt_loop_status[CONV_DONE_POS] = nxt_conv_done;
    nxt_loop_status[THERMAL_POS] = thermal_bit;
    nxt_loop_status[SYS_MIN_POS] = system_minimum_bit;
    nxt_loop_status[CUR_LOOP_POS] = current_loop_bit;
    nxt_loop_status[VOLT_LOOP_POS] = voltage_loop_bit;
    nxt_loop_status[TIMER_POS] = charge_timer_expired_bit;
    nxt_loop_status[WATCHDOG_POS] = host_watchdog_expired_bit;
  end

  // ----------------------------------------------------------------
  // Charge phase and adapter decode
  // ----------------------------------------------------------------
  logic [1:0] charge_phase_field;
  logic [2:0] adapter_type_field;
  logic [DATA_W-1:0] nxt_phase_status;

  // Charge phase passes straight through its two-bit code
  always_comb begin
    unique case (charge_phase_in)
      PHASE_CC: charge_phase_field = PHASE_CC;
      PHASE_CV: charge_phase_field = PHASE_CV;
      PHASE_TOPOFF: charge_phase_field = PHASE_TOPOFF;
      default: charge_phase_field = PHASE_IDLE;
    endcase
  end

  // Adapter type selection per variant
  always_comb begin
    adapter_type_field = ADP_NONE;
    if (mode.boost_mode) begin
      adapter_type_field = ADP_BOOST;
    end else if (!HAS_ADAPTER_DETECT) begin
      if (mode.input_present) begin
        adapter_type_field = ADP_UNKNOWN;
      end else begin
        adapter_type_field = ADP_NONE;
      end
    end else if (!adapter.auto_adapter_detect_enable || !adapter.qualified) begin
      adapter_type_field = ADP_NONE;
    end else begin
      unique case (adapter.detected_type)
        ADP_SDP, ADP_CDP, ADP_DCP, ADP_UNKNOWN, ADP_NONSTD: begin
          adapter_type_field = adapter.detected_type;
        end
        default: begin
          adapter_type_field = ADP_UNKNOWN;
        end
      endcase
    end
  end

  // Pack the second status register; bits 7:5 stay zero
  always_comb begin
    nxt_phase_status = STATUS_RESET;
    nxt_phase_status[PHASE_LSB +: 2] = charge_phase_field;
    nxt_phase_status[ADAPTER_LSB +: 3] = adapter_type_field;
  end

  // ----------------------------------------------------------------
  // Status register flops
  // ----------------------------------------------------------------

  // Live status, never loaded from the write port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      charger_loop_status_ff <= STATUS_RESET;
      charge_phase_adapter_status_ff <= STATUS_RESET;
    end else begin
      charger_loop_status_ff <= nxt_loop_status;
      charge_phase_adapter_status_ff <= nxt_phase_status;
    end
  end

  // ----------------------------------------------------------------
  // Event latches
  // ----------------------------------------------------------------
  logic [NUM_EVENTS-1:0] prev_cond_ff;
  logic [NUM_EVENTS-1:0] rise;

  // Previous condition levels for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_cond_ff <= '0;
    end else begin
      prev_cond_ff <= nxt_loop_status[NUM_EVENTS-1:0];
    end
  end

  assign rise = nxt_loop_status[NUM_EVENTS-1:0] & ~prev_cond_ff;

  // Rising edge sets; a same-cycle clear loses to the set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_event_latch_ff <= '0;
    end else begin
      watchdog_event_latch_ff <= (watchdog_event_latch_ff & ~event_clear) | rise;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] nxt_rdata;

  // Address decode; unmapped reads return zero
  always_comb begin
    unique case (reg_addr)
      LOOP_STATUS_OFS: nxt_rdata = charger_loop_status_ff;
      PHASE_ADAPTER_OFS: nxt_rdata = charge_phase_adapter_status_ff;
      default: nxt_rdata = UNMAPPED_DATA;
    endcase
  end

  // Read data and valid; a write in the same cycle cancels the read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_ff <= UNMAPPED_DATA;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd && !reg_wr;
      if (reg_rd && !reg_wr) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Write data is accepted and dropped
  logic unused_wr;
  assign unused_wr = ^{reg_wr, reg_wdata};

endmodule : csr_status_regs
`default_nettype wire

// ---- core/csr_pkg.sv ----
// Purpose: Constants and types for the charger status register bank
// Assumes: Registers reached through the serial interface register port
// Notes: All values 8 bits wide unless stated
`default_nettype none
package csr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LOOP_STATUS_OFS = 8'h1D;
  localparam logic [7:0] PHASE_ADAPTER_OFS = 8'h1E;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Loop status field positions
  // ----------------------------------------------------------------
  localparam int CONV_DONE_POS = 6;
  localparam int THERMAL_POS = 5;
  localparam int SYS_MIN_POS = 4;
  localparam int CUR_LOOP_POS = 3;
  localparam int VOLT_LOOP_POS = 2;
  localparam int TIMER_POS = 1;
  localparam int WATCHDOG_POS = 0;
  localparam int NUM_EVENTS = 7;

  // ----------------------------------------------------------------
  // Phase and adapter field positions
  // ----------------------------------------------------------------
  localparam int PHASE_LSB = 3;
  localparam int ADAPTER_LSB = 0;

  // Charge phase codes
  localparam logic [1:0] PHASE_IDLE = 2'h0;
  localparam logic [1:0] PHASE_CC = 2'h1;
  localparam logic [1:0] PHASE_CV = 2'h2;
  localparam logic [1:0] PHASE_TOPOFF = 2'h3;

  // Adapter type codes
  localparam logic [2:0] ADP_NONE = 3'h0;
  localparam logic [2:0] ADP_SDP = 3'h1;
  localparam logic [2:0] ADP_CDP = 3'h2;
  localparam logic [2:0] ADP_DCP = 3'h3;
  localparam logic [2:0] ADP_UNKNOWN = 3'h4;
  localparam logic [2:0] ADP_NONSTD = 3'h5;
  localparam logic [2:0] ADP_RESERVED = 3'h6;
  localparam logic [2:0] ADP_BOOST = 3'h7;

  // Live conditions from the control loops and timers
  typedef struct packed {
    logic thermal_active;
    logic sys_min_active;
    logic in_cur_active;
    logic limit_pin_active;
    logic boost_cur_active;
    logic in_volt_active;
    logic boost_volt_active;
    logic timer_expired;
    logic watchdog_expired;
  } csr_loops_s;

  // Operating mode of the power stage
  typedef struct packed {
    logic forward_mode;
    logic boost_mode;
    logic backup_mode;
    logic input_present;
  } csr_mode_s;

  // Adapter detector results
  typedef struct packed {
    logic auto_adapter_detect_enable;
    logic qualified;
    logic [2:0] detected_type;
  } csr_adapter_s;
endpackage : csr_pkg
`default_nettype wire

// ---- testbench/csr_status_regs_chk.sv ----
// Purpose: Port assertions for the charger status bank
// Assumes: One clock, synchronous reset
// Notes: Bound to every bank instance
`default_nettype none
module csr_status_chk
  import csr_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire csr_pkg::csr_loops_s loops,
  input wire csr_pkg::csr_mode_s mode,
  input wire logic [1:0] charge_phase_in,
  input wire logic conv_continuous,
  input wire logic conv_finish,
  input wire logic reg_wr,
  input wire logic reg_rvalid_ff,
  input wire logic [DATA_W-1:0] charger_loop_status_ff,
  input wire logic [DATA_W-1:0] charge_phase_adapter_status_ff,
  input wire logic [csr_pkg::NUM_EVENTS-1:0] watchdog_event_latch_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_rst;
    $past(sys_rst) |-> charger_loop_status_ff == 8'h00
      && charge_phase_adapter_status_ff == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("status not clear after reset");
  property p_rsvd;
    !charger_loop_status_ff[7] && charge_phase_adapter_status_ff[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_wd;
    1'b1 |=> charger_loop_status_ff[0] == $past(loops.watchdog_expired);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog bit wrong");
  property p_th;
    charger_loop_status_ff[5] |-> $past(loops.thermal_active);
  endproperty
  a_th: assert property (p_th) else $error("thermal bit without cause");
  property p_cont;
    conv_continuous |=> !charger_loop_status_ff[6];
  endproperty
  a_cont: assert property (p_cont) else $error("done bit in continuous mode");
  property p_fin;
    conv_finish && !conv_continuous |=> charger_loop_status_ff[6];
  endproperty
  a_fin: assert property (p_fin) else $error("done bit missing");
  property p_phase;
    1'b1 |=> charge_phase_adapter_status_ff[4:3] == $past(charge_phase_in);
  endproperty
  a_phase: assert property (p_phase) else $error("phase field wrong");
  property p_boost;
    mode.boost_mode |=> charge_phase_adapter_status_ff[2:0] == ADP_BOOST;
  endproperty
  a_boost: assert property (p_boost) else $error("boost code missing");
  property p_nores;
    charge_phase_adapter_status_ff[2:0] != ADP_RESERVED;
  endproperty
  a_nores: assert property (p_nores) else $error("reserved adapter code");
  property p_wr;
    reg_wr |=> !reg_rvalid_ff;
  endproperty
  a_wr: assert property (p_wr) else $error("write gave read data");
  property p_evt;
    $rose(charger_loop_status_ff[0]) |-> watchdog_event_latch_ff[0];
  endproperty
  a_evt: assert property (p_evt) else $error("event flag not latched");
endmodule : csr_status_chk

bind csr_status_regs csr_status_chk #(
  .DATA_W(DATA_W)
) u_chk (
  .clk, .sys_rst, .loops, .mode, .charge_phase_in, .conv_continuous, .conv_finish,
  .reg_wr, .reg_rvalid_ff, .charger_loop_status_ff, .charge_phase_adapter_status_ff,
  .watchdog_event_latch_ff
);
`default_nettype wire

// ---- testbench/csr_host_model.sv ----
// Purpose: Host side of the status register port
// Assumes: Bench picks one access kind per cycle
// Notes: Idle lines carry inverted values
`default_nettype none
module csr_host_model (
  input wire logic sys_rst,
  input wire logic [1:0] kind,
  input wire logic [7:0] addr,
  input wire logic [7:0] data,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobes held off during reset
  assign reg_rd = kind[0] && !sys_rst;
  assign reg_wr = kind[1] && !sys_rst;
  // Released lines show the inverse
  assign reg_addr = |kind ? addr : ~addr;
  assign reg_wdata = kind[1] ? data : ~data;
endmodule : csr_host_model
`default_nettype wire

// ---- testbench/test_charger_status_registers.sv ----
// Purpose: Random self-check of the charger status bank
// Assumes: Inputs change at the falling edge
// Notes: Both adapter variants run side by side
`default_nettype none
module test_charger_status_registers;
  timeunit 1ns;
  timeprecision 1ps;
  import csr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  csr_loops_s loops = '0;
  csr_mode_s mode = '0;
  csr_adapter_s adapter = '0;
  logic [1:0] phase = 2'h0, kind = 2'h0;
  logic cont = 1'b0, c_st = 1'b0, c_fn = 1'b0, rd, wr, rv;
  logic [7:0] addr = 8'h00, wdat = 8'h00, ra, wd, rdata, ls, pa, pa2;
  logic [6:0] clr = 7'h00, lat;
  logic [7:0] e_ls = 8'h00, e_pa = 8'h00, e_pa2 = 8'h00, e_rd = 8'h00;
  logic [6:0] e_lat = 7'h00;
  logic e_rv = 1'b0, conv = 1'b0;
  int failures = 0, num_checks = 0;

  // Clock
  always #4 clk = ~clk;

  // Host and both variants
  csr_host_model HOST (.sys_rst, .kind, .addr, .data(wdat), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(ra), .reg_wdata(wd));
  csr_status_regs DUT (.clk, .sys_rst, .loops, .mode, .adapter, .charge_phase_in(phase),
    .conv_continuous(cont), .conv_start(c_st), .conv_finish(c_fn), .reg_rd(rd),
    .reg_wr(wr), .reg_addr(ra), .reg_wdata(wd), .event_clear(clr), .reg_rdata_ff(rdata),
    .reg_rvalid_ff(rv), .charger_loop_status_ff(ls), .charge_phase_adapter_status_ff(pa),
    .watchdog_event_latch_ff(lat));
  csr_status_regs #(.HAS_ADAPTER_DETECT(1'b0)) DUT_PLAIN (.clk, .sys_rst, .loops, .mode,
    .adapter, .charge_phase_in(phase), .conv_continuous(cont), .conv_start(c_st),
    .conv_finish(c_fn), .reg_rd(rd), .reg_wr(wr), .reg_addr(ra), .reg_wdata(wd),
    .event_clear(clr), .reg_rdata_ff(), .reg_rvalid_ff(), .charger_loop_status_ff(),
    .charge_phase_adapter_status_ff(pa2), .watchdog_event_latch_ff());

  // --------
  // Tasks
  // --------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // Check last edge, drive new inputs, predict next edge
  task automatic step(input bit rst);
    logic [31:0] r;
    logic [7:0] n;
    logic [2:0] t;
    cmp(ls, e_ls);
    cmp(pa, e_pa);
    cmp(pa2, e_pa2);
    cmp({1'b0, lat}, {1'b0, e_lat});
    cmp({7'h00, rv}, {7'h00, e_rv});
    cmp(rdata, e_rd);
    r = $urandom;
    sys_rst = rst;
    loops = r[8:0];
    adapter = r[13:9];
    phase = r[15:14];
    kind = r[17:16];
    cont = r[20:18] == 3'h0;
    c_st = r[22:21] == 2'h0;
    c_fn = r[24:23] == 2'h0;
    addr = 8'h1C + {6'h00, r[26:25]};
    mode[3:1] = 3'h4 >> r[28:27];
    mode.input_present = r[29];
    r = $urandom;
    clr = r[8:7] == 2'h0 ? r[6:0] : 7'h00;
    wdat = r[31:24];
    if (rst) begin
      {e_ls, e_pa, e_pa2, e_rd, e_lat, e_rv, conv} = '0;
    end else begin
      e_rv = kind == 2'h1;
      if (e_rv) begin
        e_rd = addr == LOOP_STATUS_OFS ? e_ls : addr == PHASE_ADAPTER_OFS ? e_pa : 8'h00;
      end
      conv = cont ? 1'b0 : c_fn ? 1'b1 : c_st ? 1'b0 : conv;
      n[7:6] = {1'b0, conv};
      n[5] = loops.thermal_active;
      n[4] = mode.forward_mode & loops.sys_min_active;
      n[3] = mode.forward_mode ? loops.in_cur_active | loops.limit_pin_active
        : mode.boost_mode & loops.boost_cur_active;
      n[2] = mode.forward_mode ? loops.in_volt_active
        : (mode.boost_mode | mode.backup_mode) & loops.boost_volt_active;
      n[1:0] = {loops.timer_expired, loops.watchdog_expired};
      e_lat = (e_lat & ~clr) | (n[6:0] & ~e_ls[6:0]);
      e_ls = n;
      t = adapter.detected_type;
      if (mode.boost_mode) t = ADP_BOOST;
      else if (!adapter.auto_adapter_detect_enable || !adapter.qualified) t = ADP_NONE;
      else if (t == ADP_NONE || t >= ADP_RESERVED) t = ADP_UNKNOWN;
      e_pa = {3'h0, phase, t};
      e_pa2 = {3'h0, phase, mode.boost_mode ? ADP_BOOST
        : mode.input_present ? ADP_UNKNOWN : ADP_NONE};
    end
  endtask : step

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Main sequence with a reset in mid-run
  initial begin
    void'($urandom(97));
    repeat (2) @(posedge clk);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      step(i == 1500 || i == 1501);
      if (i % 1500 == 1499) $display("test %0d done", i / 1500);
    end
    summarize();
  end
endmodule : test_charger_status_registers
`default_nettype wire
